// *** hw/sra_pkg.sv ***
// Package: address map, sub-address maps and reset values of the subbank register block
package sra_pkg;
    typedef logic [15:0] sra_word_t;

    // ***************************************
    // Directly decoded data-memory locations
    // ***************************************
    localparam sra_word_t SRA_ADDR_SER0_PTR = 16'h0038;
    localparam sra_word_t SRA_ADDR_SER0_DATA = 16'h0039;
    localparam sra_word_t SRA_ADDR_SER1_PTR = 16'h0048;
    localparam sra_word_t SRA_ADDR_SER1_DATA = 16'h0049;
    localparam sra_word_t SRA_ADDR_DMA_PREC = 16'h0054;
    localparam sra_word_t SRA_ADDR_DMA_PTR = 16'h0055;
    localparam sra_word_t SRA_ADDR_DMA_INC = 16'h0056;
    localparam sra_word_t SRA_ADDR_DMA_PLAIN = 16'h0057;

    // ***************************************
    // Reset values
    // ***************************************
    localparam sra_word_t SRA_PTR_RESET = 16'h0000;
    localparam sra_word_t SRA_REG_RESET = 16'h0000;
    localparam sra_word_t SRA_READ_MISS = 16'h0000;

    // ***************************************
    // Serial-port sub-address map
    // ***************************************
    localparam int SRA_SER_DEPTH = 15;
    localparam int SRA_SUB_PORT_CTRL1 = 'h00;
    localparam int SRA_SUB_PORT_CTRL2 = 'h01;
    localparam int SRA_SUB_RX_CTRL1 = 'h02;
    localparam int SRA_SUB_RX_CTRL2 = 'h03;
    localparam int SRA_SUB_TX_CTRL1 = 'h04;
    localparam int SRA_SUB_TX_CTRL2 = 'h05;
    localparam int SRA_SUB_SRG_CFG1 = 'h06;
    localparam int SRA_SUB_SRG_CFG2 = 'h07;
    localparam int SRA_SUB_MC_CFG1 = 'h08;
    localparam int SRA_SUB_MC_CFG2 = 'h09;
    localparam int SRA_SUB_RX_EN_A = 'h0A;
    localparam int SRA_SUB_RX_EN_B = 'h0B;
    localparam int SRA_SUB_TX_EN_A = 'h0C;
    localparam int SRA_SUB_TX_EN_B = 'h0D;
    localparam int SRA_SUB_PIN_CTRL = 'h0E;

    // ***************************************
    // DMA sub-address map
    // ***************************************
    localparam int SRA_DMA_DEPTH = 40;
    localparam int SRA_DMA_CHANNELS = 6;
    localparam int SRA_DMA_CH_STRIDE = 5;
    localparam int SRA_DMA_FLD_SRC = 0;
    localparam int SRA_DMA_FLD_DST = 1;
    localparam int SRA_DMA_FLD_COUNT = 2;
    localparam int SRA_DMA_FLD_SYNC = 3;
    localparam int SRA_DMA_FLD_MODE = 4;
    localparam int SRA_SUB_SRC_PAGE = 'h1E;
    localparam int SRA_SUB_DST_PAGE = 'h1F;
    localparam int SRA_SUB_ELEM_IDX0 = 'h20;
    localparam int SRA_SUB_ELEM_IDX1 = 'h21;
    localparam int SRA_SUB_FRAME_IDX0 = 'h22;
    localparam int SRA_SUB_FRAME_IDX1 = 'h23;
    localparam int SRA_SUB_RELOAD_SRC = 'h24;
    localparam int SRA_SUB_RELOAD_DST = 'h25;
    localparam int SRA_SUB_RELOAD_COUNT = 'h26;
    localparam int SRA_SUB_RELOAD_FRAMES = 'h27;

    typedef logic [SRA_DMA_CHANNELS-1:0][15:0] sra_chan_words_t;
endpackage

// *** hw/sra_bank_if.sv ***
// Interface: pointer, write strobe and data between the access decoder and one subbank
`timescale 1ns/1ps
interface sra_bank_if;
    logic [15:0] ptr;
    logic wrEn;
    logic [15:0] wdata;
    logic [15:0] rdata;

    modport ctrl (
        output ptr,
        output wrEn,
        output wdata,
        input rdata
    );

    modport bank (
        input ptr,
        input wrEn,
        input wdata,
        output rdata
    );
endinterface

// *** hw/sra_subbank_ptr.sv ***
// Sub-address pointer register with load and optional post-increment
`timescale 1ns/1ps
module sra_subbank_ptr (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic load,
    input wire sra_pkg::sra_word_t loadVal,
    input wire logic inc,
    output sra_pkg::sra_word_t ptr
);
    import sra_pkg::*;

    sra_word_t ptr_reg;
    sra_word_t ptr_next;
    wire sra_word_t ptrPlusOne = ptr_reg + 16'h0001;

    // A load and an increment never coincide: they come from different addresses
    assign ptr_next = load ? loadVal : (inc ? ptrPlusOne : ptr_reg);

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ptr_reg <= SRA_PTR_RESET;
        end else begin
            ptr_reg <= ptr_next;
        end
    end

    assign ptr = ptr_reg;
endmodule

// *** hw/sra_subbank.sv ***
// Subbank register storage reached through a pointer
`timescale 1ns/1ps
module sra_subbank #(
    parameter int DEPTH = 2
) (
    input wire logic clk_sys,
    input wire logic rstn,
    sra_bank_if.bank port,
    output logic [DEPTH-1:0][15:0] regs
);
    import sra_pkg::*;

    localparam int IDX_W = $clog2(DEPTH);

    logic [DEPTH-1:0][15:0] store_reg;
    wire logic inRange = (port.ptr < 16'(DEPTH));
    wire logic [IDX_W-1:0] idx = port.ptr[IDX_W-1:0];
    wire logic doWrite = port.wrEn && inRange;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            store_reg <= {DEPTH{SRA_REG_RESET}};
        end else if (doWrite) begin
            store_reg[idx] <= port.wdata;
        end
    end

    // Unlisted sub-addresses read as zero
    assign port.rdata = inRange ? store_reg[idx] : SRA_READ_MISS;
    assign regs = store_reg;
endmodule

// *** hw/sra_subbank_access.sv ***
// Top: indirect register access for two serial-port units and the DMA controller
// ***************************************
// ***************************************
`timescale 1ns/1ps
module sra_subbank_access (
    input wire logic clk_sys,
    input wire logic rstn,

    // Core data-memory bus
    input wire sra_pkg::sra_word_t busAddr,
    input wire logic busRd,
    input wire logic busWr,
    input wire sra_pkg::sra_word_t busWdata,
    output logic busSel,
    output sra_pkg::sra_word_t busRdata,
    output logic busRdValid,

    // DMA priority register
    output sra_pkg::sra_word_t dmaPriorityEnableCtrl,

    // Serial unit 0, sub-addresses 00h-0Eh
    output sra_pkg::sra_word_t ser0PortCtrl1,
    output sra_pkg::sra_word_t ser0PortCtrl2,
    output sra_pkg::sra_word_t ser0RxCtrl1,
    output sra_pkg::sra_word_t ser0RxCtrl2,
    output sra_pkg::sra_word_t ser0TxCtrl1,
    output sra_pkg::sra_word_t ser0TxCtrl2,
    output sra_pkg::sra_word_t ser0SampleRateGenCfg1,
    output sra_pkg::sra_word_t ser0SampleRateGenCfg2,
    output sra_pkg::sra_word_t ser0MultichannelCfg1,
    output sra_pkg::sra_word_t ser0MultichannelCfg2,
    output sra_pkg::sra_word_t ser0RxChannelEnableA,
    output sra_pkg::sra_word_t ser0RxChannelEnableB,
    output sra_pkg::sra_word_t ser0TxChannelEnableA,
    output sra_pkg::sra_word_t ser0TxChannelEnableB,
    output sra_pkg::sra_word_t ser0PinCtrl,

    // Serial unit 1, same map
    output sra_pkg::sra_word_t ser1PortCtrl1,
    output sra_pkg::sra_word_t ser1PortCtrl2,
    output sra_pkg::sra_word_t ser1RxCtrl1,
    output sra_pkg::sra_word_t ser1RxCtrl2,
    output sra_pkg::sra_word_t ser1TxCtrl1,
    output sra_pkg::sra_word_t ser1TxCtrl2,
    output sra_pkg::sra_word_t ser1SampleRateGenCfg1,
    output sra_pkg::sra_word_t ser1SampleRateGenCfg2,
    output sra_pkg::sra_word_t ser1MultichannelCfg1,
    output sra_pkg::sra_word_t ser1MultichannelCfg2,
    output sra_pkg::sra_word_t ser1RxChannelEnableA,
    output sra_pkg::sra_word_t ser1RxChannelEnableB,
    output sra_pkg::sra_word_t ser1TxChannelEnableA,
    output sra_pkg::sra_word_t ser1TxChannelEnableB,
    output sra_pkg::sra_word_t ser1PinCtrl,

    // DMA per-channel registers
    output sra_pkg::sra_chan_words_t dmaSrcAddr,
    output sra_pkg::sra_chan_words_t dmaDstAddr,
    output sra_pkg::sra_chan_words_t dmaElementCount,
    output sra_pkg::sra_chan_words_t dmaSyncFrameCount,
    output sra_pkg::sra_chan_words_t dmaModeCtrl,

    // DMA common registers
    output sra_pkg::sra_word_t dmaSrcProgPage,
    output sra_pkg::sra_word_t dmaDstProgPage,
    output sra_pkg::sra_word_t dmaElementIndex0,
    output sra_pkg::sra_word_t dmaElementIndex1,
    output sra_pkg::sra_word_t dmaFrameIndex0,
    output sra_pkg::sra_word_t dmaFrameIndex1,
    output sra_pkg::sra_word_t dmaReloadSrc,
    output sra_pkg::sra_word_t dmaReloadDst,
    output sra_pkg::sra_word_t dmaReloadCount,
    output sra_pkg::sra_word_t dmaReloadFrames
);
    import sra_pkg::*;

    // ***************************************
    // Address decode
    // ***************************************
    function automatic logic addrIs(input sra_word_t addr, input sra_word_t loc);
        addrIs = (addr == loc);
    endfunction

    // Full 16-bit compare, so no alias of a location hits
    wire logic hitSer0Ptr = addrIs(busAddr, SRA_ADDR_SER0_PTR);
    wire logic hitSer0Data = addrIs(busAddr, SRA_ADDR_SER0_DATA);
    wire logic hitSer1Ptr = addrIs(busAddr, SRA_ADDR_SER1_PTR);
    wire logic hitSer1Data = addrIs(busAddr, SRA_ADDR_SER1_DATA);
    wire logic hitDmaPrec = addrIs(busAddr, SRA_ADDR_DMA_PREC);
    wire logic hitDmaPtr = addrIs(busAddr, SRA_ADDR_DMA_PTR);
    wire logic hitDmaInc = addrIs(busAddr, SRA_ADDR_DMA_INC);
    wire logic hitDmaPlain = addrIs(busAddr, SRA_ADDR_DMA_PLAIN);
    wire logic hitDmaData = hitDmaInc || hitDmaPlain;
    wire logic busAccess = busRd || busWr;

    assign busSel = hitSer0Ptr || hitSer0Data || hitSer1Ptr || hitSer1Data ||
                    hitDmaPrec || hitDmaPtr || hitDmaData;

    // ***************************************
    // Write strobes
    // ***************************************
    // Every write lands on the edge that takes it
    wire logic wrSer0Ptr = busWr && hitSer0Ptr;
    wire logic wrSer1Ptr = busWr && hitSer1Ptr;
    wire logic wrDmaPtr = busWr && hitDmaPtr;
    wire logic wrSer0Data = busWr && hitSer0Data;
    wire logic wrSer1Data = busWr && hitSer1Data;
    wire logic wrDmaData = busWr && hitDmaData;
    wire logic wrDmaPrec = busWr && hitDmaPrec;

    // ***************************************
    // Pointers
    // ***************************************
    sra_bank_if ser0If ();
    sra_bank_if ser1If ();
    sra_bank_if dmaIf ();

    // Only the DMA bank increments; the serial pointers change only by a write
    wire logic dmaPtrInc = hitDmaInc && busAccess;

    sra_subbank_ptr u_ser0Ptr (
        .clk_sys (clk_sys),
        .rstn (rstn),
        .load (wrSer0Ptr),
        .loadVal (busWdata),
        .inc (1'b0),
        .ptr (ser0If.ptr)
    );

    sra_subbank_ptr u_ser1Ptr (
        .clk_sys (clk_sys),
        .rstn (rstn),
        .load (wrSer1Ptr),
        .loadVal (busWdata),
        .inc (1'b0),
        .ptr (ser1If.ptr)
    );

    // ***************************************
    // DMA pointer
    // ***************************************
    sra_subbank_ptr u_dmaPtr (
        .clk_sys (clk_sys),
        .rstn (rstn),
        .load (wrDmaPtr),
        .loadVal (busWdata),
        .inc (dmaPtrInc),
        .ptr (dmaIf.ptr)
    );

    // ***************************************
    // Subbank storage
    // ***************************************
    // Each instance sees writes only from its own data location
    assign ser0If.wrEn = wrSer0Data;
    assign ser1If.wrEn = wrSer1Data;
    assign dmaIf.wrEn = wrDmaData;
    assign ser0If.wdata = busWdata;
    assign ser1If.wdata = busWdata;
    assign dmaIf.wdata = busWdata;

    logic [SRA_SER_DEPTH-1:0][15:0] ser0Regs;
    logic [SRA_SER_DEPTH-1:0][15:0] ser1Regs;
    logic [SRA_DMA_DEPTH-1:0][15:0] dmaRegs;

    sra_subbank #(
        .DEPTH (SRA_SER_DEPTH)
    ) u_ser0Bank (
        .clk_sys (clk_sys),
        .rstn (rstn),
        .port (ser0If.bank),
        .regs (ser0Regs)
    );

    sra_subbank #(
        .DEPTH (SRA_SER_DEPTH)
    ) u_ser1Bank (
        .clk_sys (clk_sys),
        .rstn (rstn),
        .port (ser1If.bank),
        .regs (ser1Regs)
    );

    sra_subbank #(
        .DEPTH (SRA_DMA_DEPTH)
    ) u_dmaBank (
        .clk_sys (clk_sys),
        .rstn (rstn),
        .port (dmaIf.bank),
        .regs (dmaRegs)
    );

    // ***************************************
    // Directly mapped DMA priority register
    // ***************************************
    // Own address; the DMA pointer never reaches it
    sra_word_t dmaPrec_reg;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            dmaPrec_reg <= SRA_REG_RESET;
        end else if (wrDmaPrec) begin
            dmaPrec_reg <= busWdata;
        end
    end

    assign dmaPriorityEnableCtrl = dmaPrec_reg;

    // ***************************************
    // Read path
    // ***************************************
    // Read data uses the pointer before any post-increment of the same access
    sra_word_t rdMux;

    always_comb begin
        rdMux = SRA_READ_MISS;
        if (hitSer0Ptr) begin
            rdMux = ser0If.ptr;
        end else if (hitSer0Data) begin
            rdMux = ser0If.rdata;
        end else if (hitSer1Ptr) begin
            rdMux = ser1If.ptr;
        end else if (hitSer1Data) begin
            rdMux = ser1If.rdata;
        end else if (hitDmaPrec) begin
            rdMux = dmaPrec_reg;
        end else if (hitDmaPtr) begin
            rdMux = dmaIf.ptr;
        end else if (hitDmaData) begin
            rdMux = dmaIf.rdata;
        end
    end

    // ***************************************
    // Read data register
    // ***************************************
    sra_word_t busRdata_reg;
    logic busRdValid_reg;

    // Holds between reads, so a late sample still sees the last read
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            busRdata_reg <= SRA_REG_RESET;
            busRdValid_reg <= 1'b0;
        end else begin
            busRdValid_reg <= busRd;
            if (busRd) begin
                busRdata_reg <= rdMux;
            end
        end
    end

    assign busRdata = busRdata_reg;
    assign busRdValid = busRdValid_reg;

    // ***************************************
    // Serial unit 0 register views
    // ***************************************
    assign ser0PortCtrl1 = ser0Regs[SRA_SUB_PORT_CTRL1];
    assign ser0PortCtrl2 = ser0Regs[SRA_SUB_PORT_CTRL2];
    assign ser0RxCtrl1 = ser0Regs[SRA_SUB_RX_CTRL1];
    assign ser0RxCtrl2 = ser0Regs[SRA_SUB_RX_CTRL2];
    assign ser0TxCtrl1 = ser0Regs[SRA_SUB_TX_CTRL1];
    assign ser0TxCtrl2 = ser0Regs[SRA_SUB_TX_CTRL2];
    assign ser0SampleRateGenCfg1 = ser0Regs[SRA_SUB_SRG_CFG1];
    assign ser0SampleRateGenCfg2 = ser0Regs[SRA_SUB_SRG_CFG2];

    assign ser0MultichannelCfg1 = ser0Regs[SRA_SUB_MC_CFG1];
    assign ser0MultichannelCfg2 = ser0Regs[SRA_SUB_MC_CFG2];
    assign ser0RxChannelEnableA = ser0Regs[SRA_SUB_RX_EN_A];
    assign ser0RxChannelEnableB = ser0Regs[SRA_SUB_RX_EN_B];
    assign ser0TxChannelEnableA = ser0Regs[SRA_SUB_TX_EN_A];
    assign ser0TxChannelEnableB = ser0Regs[SRA_SUB_TX_EN_B];
    assign ser0PinCtrl = ser0Regs[SRA_SUB_PIN_CTRL];

    // ***************************************
    // Serial unit 1 register views
    // ***************************************
    // Same map as unit 0, own storage
    assign ser1PortCtrl1 = ser1Regs[SRA_SUB_PORT_CTRL1];
    assign ser1PortCtrl2 = ser1Regs[SRA_SUB_PORT_CTRL2];
    assign ser1RxCtrl1 = ser1Regs[SRA_SUB_RX_CTRL1];
    assign ser1RxCtrl2 = ser1Regs[SRA_SUB_RX_CTRL2];
    assign ser1TxCtrl1 = ser1Regs[SRA_SUB_TX_CTRL1];
    assign ser1TxCtrl2 = ser1Regs[SRA_SUB_TX_CTRL2];
    assign ser1SampleRateGenCfg1 = ser1Regs[SRA_SUB_SRG_CFG1];
    assign ser1SampleRateGenCfg2 = ser1Regs[SRA_SUB_SRG_CFG2];

    assign ser1MultichannelCfg1 = ser1Regs[SRA_SUB_MC_CFG1];
    assign ser1MultichannelCfg2 = ser1Regs[SRA_SUB_MC_CFG2];
    assign ser1RxChannelEnableA = ser1Regs[SRA_SUB_RX_EN_A];
    assign ser1RxChannelEnableB = ser1Regs[SRA_SUB_RX_EN_B];
    assign ser1TxChannelEnableA = ser1Regs[SRA_SUB_TX_EN_A];
    assign ser1TxChannelEnableB = ser1Regs[SRA_SUB_TX_EN_B];
    assign ser1PinCtrl = ser1Regs[SRA_SUB_PIN_CTRL];

    // ***************************************
    // DMA channel register views
    // ***************************************
    // Channel c occupies sub-addresses 5c to 5c+4
    for (genvar ch = 0; ch < SRA_DMA_CHANNELS; ch++) begin : g_chan
        localparam int BASE = ch * SRA_DMA_CH_STRIDE;
        assign dmaSrcAddr[ch] = dmaRegs[BASE + SRA_DMA_FLD_SRC];
        assign dmaDstAddr[ch] = dmaRegs[BASE + SRA_DMA_FLD_DST];
        assign dmaElementCount[ch] = dmaRegs[BASE + SRA_DMA_FLD_COUNT];
        assign dmaSyncFrameCount[ch] = dmaRegs[BASE + SRA_DMA_FLD_SYNC];
        assign dmaModeCtrl[ch] = dmaRegs[BASE + SRA_DMA_FLD_MODE];
    end

    // ***************************************
    // DMA common register views
    // ***************************************
    assign dmaSrcProgPage = dmaRegs[SRA_SUB_SRC_PAGE];
    assign dmaDstProgPage = dmaRegs[SRA_SUB_DST_PAGE];

    assign dmaElementIndex0 = dmaRegs[SRA_SUB_ELEM_IDX0];
    assign dmaElementIndex1 = dmaRegs[SRA_SUB_ELEM_IDX1];
    assign dmaFrameIndex0 = dmaRegs[SRA_SUB_FRAME_IDX0];
    assign dmaFrameIndex1 = dmaRegs[SRA_SUB_FRAME_IDX1];

    assign dmaReloadSrc = dmaRegs[SRA_SUB_RELOAD_SRC];
    assign dmaReloadDst = dmaRegs[SRA_SUB_RELOAD_DST];
    assign dmaReloadCount = dmaRegs[SRA_SUB_RELOAD_COUNT];
    assign dmaReloadFrames = dmaRegs[SRA_SUB_RELOAD_FRAMES];
endmodule

// *** dv/sra_subbank_access_chk.sv ***
// Checker: bus and register properties of the subbank register block
`timescale 1ns/1ps
module sra_subbank_access_chk (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire sra_pkg::sra_word_t busAddr,
    input wire logic busRd,
    input wire logic busWr,
    input wire sra_pkg::sra_word_t busWdata,
    input wire logic busSel,
    input wire sra_pkg::sra_word_t busRdata,
    input wire logic busRdValid,
    input wire sra_pkg::sra_word_t dmaPriorityEnableCtrl,
    input wire sra_pkg::sra_word_t ser0PortCtrl1,
    input wire sra_pkg::sra_word_t ser1PinCtrl,
    input wire sra_pkg::sra_chan_words_t dmaSrcAddr
);
    import sra_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    sequence wrAt(a); busWr && busAddr == a; endsequence
    sequence rdAt(a); busRd && busAddr == a; endsequence
    sequence ptrSet(a, v); busWr && busAddr == a && busWdata == v; endsequence
    AST_RD_VALID: assert property (busRd |=> busRdValid)
        else $error("read not answered in next cycle");
    AST_RD_HOLD: assert property (!busRd |=> !busRdValid && $stable(busRdata))
        else $error("read data moved without a read");
    AST_SEL: assert property (busSel == (busAddr inside {[16'h0038:16'h0039], [16'h0048:16'h0049],
        [16'h0054:16'h0057]})) else $error("address decode wrong");
    AST_PREC: assert property (wrAt(SRA_ADDR_DMA_PREC) |=> dmaPriorityEnableCtrl == $past(busWdata))
        else $error("priority register not written directly");
    AST_SER0_FIRST: assert property (ptrSet(SRA_ADDR_SER0_PTR, 16'h0000) ##1 wrAt(SRA_ADDR_SER0_DATA)
        |=> ser0PortCtrl1 == $past(busWdata)) else $error("serial unit 0 sub 00h write lost");
    AST_SER1_PIN: assert property (ptrSet(SRA_ADDR_SER1_PTR, 16'h000E) ##1 wrAt(SRA_ADDR_SER1_DATA)
        |=> ser1PinCtrl == $past(busWdata)) else $error("serial unit 1 sub 0Eh write lost");
    AST_DMA_CH0: assert property (ptrSet(SRA_ADDR_DMA_PTR, 16'h0000) ##1 wrAt(SRA_ADDR_DMA_PLAIN)
        |=> dmaSrcAddr[0] == $past(busWdata)) else $error("channel 0 source write lost");
    AST_AUTOINC: assert property (wrAt(SRA_ADDR_DMA_PTR) ##1 rdAt(SRA_ADDR_DMA_INC) ##1 rdAt(SRA_ADDR_DMA_PTR)
        |=> busRdata == 16'($past(busWdata, 3) + 16'h0001)) else $error("pointer not stepped");
    AST_PLAIN_KEEP: assert property (wrAt(SRA_ADDR_DMA_PTR) ##1 rdAt(SRA_ADDR_DMA_PLAIN) ##1 rdAt(SRA_ADDR_DMA_PTR)
        |=> busRdata == $past(busWdata, 3)) else $error("pointer moved on plain port");
    AST_RESET: assert property ($rose(rstn) |-> !busRdValid && busRdata == SRA_REG_RESET)
        else $error("read port not cleared by reset");
endmodule
bind sra_subbank_access sra_subbank_access_chk chk (.clk_sys(clk_sys), .rstn(rstn), .busAddr(busAddr),
    .busRd(busRd), .busWr(busWr), .busWdata(busWdata), .busSel(busSel), .busRdata(busRdata),
    .busRdValid(busRdValid), .dmaPriorityEnableCtrl(dmaPriorityEnableCtrl), .ser0PortCtrl1(ser0PortCtrl1),
    .ser1PinCtrl(ser1PinCtrl), .dmaSrcAddr(dmaSrcAddr));

// *** dv/sra_core_model.sv ***
// Core model: single-cycle data-memory reads and writes toward the block
`timescale 1ns/1ps
module sra_core_model (
    input wire logic clk_sys,
    output sra_pkg::sra_word_t busAddr,
    output logic busRd,
    output logic busWr,
    output sra_pkg::sra_word_t busWdata
);
    import sra_pkg::*;
    initial begin
        busAddr = 16'h00FF;
        busRd = 1'b0;
        busWr = 1'b0;
        busWdata = 16'h0000;
    end
    // One access per call, held for one cycle; reads drive inverted write data
    task automatic access(input sra_word_t a, input logic wr, input sra_word_t d);
        busAddr <= a;
        busRd <= ~wr;
        busWr <= wr;
        busWdata <= wr ? d : ~busWdata;
        @(posedge clk_sys);
    endtask
    // Released bus inverts so a stale value never passes for a request
    task automatic idle();
        busAddr <= ~busAddr;
        busRd <= 1'b0;
        busWr <= 1'b0;
        busWdata <= ~busWdata;
        @(posedge clk_sys);
    endtask
endmodule

// *** dv/test_sra_subbank_access.sv ***
// Testbench: reference model with directed and random traffic for the subbank block
`timescale 1ns/1ps
module test_sra_subbank_access;
    import sra_pkg::*;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    sra_word_t busAddr, busWdata, busRdata, prec;
    logic busRd, busWr, busSel, busRdValid;
    sra_word_t s0 [15];
    sra_word_t s1 [15];
    sra_word_t dc [10];
    sra_chan_words_t dS, dD, dC, dF, dM;
    int miscompares = 0;
    int checks = 0;
    int sPtr [2];
    int sReg [2][15];
    int dPtr, mPrec;
    int dReg [40];
    int expq [$];
    logic [31:0] seed = 32'd83460;
    always #2 clk_sys = ~clk_sys;
    sra_core_model core (.clk_sys(clk_sys), .busAddr(busAddr), .busRd(busRd), .busWr(busWr), .busWdata(busWdata));
    sra_subbank_access dut (.clk_sys(clk_sys), .rstn(rstn), .busAddr(busAddr), .busRd(busRd), .busWr(busWr),
        .busWdata(busWdata), .busSel(busSel), .busRdata(busRdata), .busRdValid(busRdValid),
        .dmaPriorityEnableCtrl(prec), .ser0PortCtrl1(s0[0]), .ser0PortCtrl2(s0[1]), .ser0RxCtrl1(s0[2]),
        .ser0RxCtrl2(s0[3]), .ser0TxCtrl1(s0[4]), .ser0TxCtrl2(s0[5]), .ser0SampleRateGenCfg1(s0[6]),
        .ser0SampleRateGenCfg2(s0[7]), .ser0MultichannelCfg1(s0[8]), .ser0MultichannelCfg2(s0[9]),
        .ser0RxChannelEnableA(s0[10]), .ser0RxChannelEnableB(s0[11]), .ser0TxChannelEnableA(s0[12]),
        .ser0TxChannelEnableB(s0[13]), .ser0PinCtrl(s0[14]), .ser1PortCtrl1(s1[0]), .ser1PortCtrl2(s1[1]),
        .ser1RxCtrl1(s1[2]), .ser1RxCtrl2(s1[3]), .ser1TxCtrl1(s1[4]), .ser1TxCtrl2(s1[5]),
        .ser1SampleRateGenCfg1(s1[6]), .ser1SampleRateGenCfg2(s1[7]), .ser1MultichannelCfg1(s1[8]),
        .ser1MultichannelCfg2(s1[9]), .ser1RxChannelEnableA(s1[10]), .ser1RxChannelEnableB(s1[11]),
        .ser1TxChannelEnableA(s1[12]), .ser1TxChannelEnableB(s1[13]), .ser1PinCtrl(s1[14]),
        .dmaSrcAddr(dS), .dmaDstAddr(dD), .dmaElementCount(dC), .dmaSyncFrameCount(dF), .dmaModeCtrl(dM),
        .dmaSrcProgPage(dc[0]), .dmaDstProgPage(dc[1]), .dmaElementIndex0(dc[2]), .dmaElementIndex1(dc[3]),
        .dmaFrameIndex0(dc[4]), .dmaFrameIndex1(dc[5]), .dmaReloadSrc(dc[6]), .dmaReloadDst(dc[7]),
        .dmaReloadCount(dc[8]), .dmaReloadFrames(dc[9]));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input sra_word_t got, input int exp);
        checks++;
        if (got !== exp[15:0]) begin
            miscompares++;
            $display("wrong value at %0t ns: got %h expected %h", $time, got, exp[15:0]);
        end
    endtask
    task automatic mdlReset();
        sPtr = '{0, 0};
        sReg = '{default: 0};
        dReg = '{default: 0};
        dPtr = 0;
        mPrec = 0;
    endtask
    // Reference: unlisted sub-addresses read zero and drop writes
    function automatic int mdl(int a, bit wr, int d);
        int r;
        int u;
        r = 0;
        u = (a >= 'h48) ? 1 : 0;
        if (a == 'h38 || a == 'h48) begin
            r = sPtr[u];
            if (wr) sPtr[u] = d & 'hFFFF;
        end else if (a == 'h39 || a == 'h49) begin
            if (sPtr[u] < 15) r = sReg[u][sPtr[u]];
            if (wr && sPtr[u] < 15) sReg[u][sPtr[u]] = d & 'hFFFF;
        end else if (a == 'h54) begin
            r = mPrec;
            if (wr) mPrec = d & 'hFFFF;
        end else if (a == 'h55) begin
            r = dPtr;
            if (wr) dPtr = d & 'hFFFF;
        end else if (a == 'h56 || a == 'h57) begin
            if (dPtr < 40) r = dReg[dPtr];
            if (wr && dPtr < 40) dReg[dPtr] = d & 'hFFFF;
            if (a == 'h56) dPtr = (dPtr + 1) & 'hFFFF;
        end
        return r;
    endfunction
    task automatic op(input int a, input bit wr, input int d);
        int r;
        r = mdl(a, wr, d);
        if (!wr) expq.push_back(r);
        core.access(a[15:0], wr, d[15:0]);
    endtask
    task automatic chkRegs();
        chk(prec, mPrec);
        for (int i = 0; i < 15; i++) begin
            chk(s0[i], sReg[0][i]);
            chk(s1[i], sReg[1][i]);
        end
        for (int c = 0; c < 6; c++) begin
            chk(dS[c], dReg[5*c]);
            chk(dD[c], dReg[5*c+1]);
            chk(dC[c], dReg[5*c+2]);
            chk(dF[c], dReg[5*c+3]);
            chk(dM[c], dReg[5*c+4]);
        end
        for (int i = 0; i < 10; i++) chk(dc[i], dReg[30+i]);
    endtask
    task automatic test_done();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Every read result is held against the reference
    always @(posedge clk_sys) begin
        if (rstn && busRdValid === 1'b1) begin
            if (expq.size() != 0) chk(busRdata, expq.pop_front());
            else chk(16'h0000, 1);
        end
    end
    initial begin
        repeat (5000) @(posedge clk_sys);
        miscompares++;
        test_done();
    end
    initial begin
        logic [31:0] r;
        int a;
        int adr [10] = '{'h38, 'h39, 'h48, 'h49, 'h54, 'h55, 'h56, 'h57, 'h3A, 'h58};
        mdlReset();
        repeat (12) @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
        foreach (adr[i]) op(adr[i], 0, 0);
        chkRegs();
        $display("reset values done");
        for (int u = 0; u < 2; u++) begin
            for (int s = 0; s < 16; s++) begin
                op('h38 + 16*u, 1, s);
                op('h39 + 16*u, 1, rnd());
            end
            for (int s = 16; s >= 0; s--) begin
                op('h38 + 16*u, 1, s);
                op('h39 + 16*u, 0, 0);
            end
        end
        core.idle();
        chkRegs();
        $display("serial maps done");
        op('h55, 1, 0);
        for (int s = 0; s < 42; s++) op('h56, 1, rnd());
        op('h55, 0, 0);
        for (int s = 0; s < 40; s += 7) begin
            op('h55, 1, s);
            op('h57, 0, 0);
            op('h55, 0, 0);
            op('h57, 1, rnd());
        end
        op('h55, 1, 0);
        op('h57, 1, rnd());
        op('h55, 1, 'hFFFF);
        op('h56, 0, 0);
        op('h55, 0, 0);
        op('h54, 1, rnd());
        op('h54, 0, 0);
        op('h55, 1, 0);
        for (int s = 0; s < 40; s++) op('h56, 0, 0);
        core.idle();
        chkRegs();
        $display("dma bank done");
        for (int n = 0; n < 400; n++) begin
            r = rnd();
            a = adr[r[3:0] % 10];
            op(a, r[4], (a == 'h38 || a == 'h48 || a == 'h55) ? int'(r[21:16]) : int'(r[31:16]));
        end
        // Two idle cycles: the last read answer is popped before the queue is counted
        core.idle();
        core.idle();
        chkRegs();
        chk(16'(expq.size()), 0);
        $display("random traffic done");
        rstn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        mdlReset();
        chkRegs();
        chk(busRdata, 0);
        rstn <= 1'b1;
        @(posedge clk_sys);
        op('h48, 0, 0);
        op('h55, 0, 0);
        core.idle();
        core.idle();
        $display("second reset done");
        test_done();
    end
endmodule
